//--- rtl/sadc_defs.svh
// Constants for the successive-approximation conversion control
`ifndef SADC_DEFS_SVH
`define SADC_DEFS_SVH
`define SADC_RES_BITS      8
`define SADC_DIV_RATIO     8
`define SADC_DIV_W         3
`define SADC_DIV_LAST      3'h7
`define SADC_SHIFT_W       9
`define SADC_SHIFT_CLR     9'h000
`define SADC_RESULT_RST    8'h00
`define SADC_DONE_HOLD     4'h8
`define SADC_HOLD_W        4
`define SADC_FULL_SCALE    8'hff
`endif

//--- rtl/sadc_pkg.sv
// Types for the successive-approximation conversion control
`default_nettype none
`include "sadc_defs.svh"
package sadc_pkg;
   typedef enum logic [1:0] {
      SADC_IDLE  = 2'b00,
      SADC_ARMED = 2'b01,
      SADC_RUN   = 2'b11,
      SADC_END   = 2'b10
   } sadc_state_t;

   typedef struct packed {
      logic cs_n;
      logic wr_n;
      logic rd_n;
      logic cmp;
   } sadc_pins_t;

   typedef struct packed {
      logic [1:0] s1;
      logic [1:0] s2;
      logic [1:0] s3;
      logic [1:0] s4;
   } sadc_sync_t;

   typedef struct packed {
      sadc_sync_t                     sync;
      logic                           wr_n_prev;
      logic                           rd_n_prev;
      sadc_state_t                    state;
      logic                           start_ff;
      logic [`SADC_DIV_W-1:0]         div;
      logic [`SADC_SHIFT_W-1:0]       shift;
      logic [`SADC_RES_BITS-1:0]      sar;
      logic [`SADC_RES_BITS-1:0]      result;
      logic                           done_ff;
      logic [`SADC_HOLD_W-1:0]        hold;
      logic                           oe;
      logic [`SADC_RES_BITS-1:0]      trial;
   } sadc_state_all_t;
endpackage : sadc_pkg
`default_nettype wire

//--- rtl/sadc_ctrl.sv
// Conversion control: start logic, bit search, result latch, done flag
// Notes on behaviour
// (R1) Eight MSB-first comparisons over 64 clocks
// (R2) Result latched first, then done flag falls
// (R3) New start aborts running conversion
// (R4) Done fed to start restarts continuously
// (R5) Controller gives no start after power-up
// (R6) Start strobe fall clears search and shifter
// (R7) Held in reset; starts 1-8 clocks later
// (R8) Start flop clears shifter, done, seeds token
// (R9) Clear pulse ignored while set persists
// (R10) Token exit loads output, then sets done
// (R11) Sequencer runs at one eighth clock
// (R12) Done low eight clocks despite held read
// (R13) Falling done restarts, giving short pulse
// (R14) Chip select and read clear done, drive bus
// (R15) Negative input above positive gives zero
// (R16) Start or read fall clears done flag
// (R17) Bus released and latch kept otherwise
`default_nettype none
`include "sadc_defs.svh"
module sadc_ctrl (
   // Clock and reset
   input  wire logic                      clk,
   input  wire logic                      rst_b,
   input  wire logic                      clk_en,
   // Bus strobes, asynchronous pins
   input  wire logic                      cs_n,
   input  wire logic                      wr_n,
   input  wire logic                      rd_n,
   // Analog comparator: high when input exceeds trial tap
   input  wire logic                      cmp_hi,
   // Trial code to the ladder
   output logic [`SADC_RES_BITS-1:0]      trial_code,
   // Data bus pins
   output logic [`SADC_RES_BITS-1:0]      data_o,
   output logic [`SADC_RES_BITS-1:0]      data_oe,
   // End-of-conversion flag, active low
   output logic                           done_flag_n,
   output logic                           busy
);
   sadc_pkg::sadc_state_all_t q, d;
   sadc_pkg::sadc_pins_t      pin;
   logic                      set_cond;
   logic                      wr_fall;
   logic                      rd_fall;
   logic                      read_on;
   logic                      tick;
   logic                      first_stage_flop;
   logic                      restart_clear_gate;
   logic                      result_load_gate;
   logic                      hold_idle;
   logic                      hold_last;
   logic                      busy_d;
   logic [`SADC_RES_BITS-1:0] bit_now;
   logic [`SADC_RES_BITS-1:0] decided;
   logic [`SADC_RES_BITS-1:0] next_trial;

   // Stage k of the shifter decides bit RES_BITS-k, so the top bit goes first
   function automatic logic [`SADC_RES_BITS-1:0] bit_of(
      input logic [`SADC_SHIFT_W-1:0] sh
   );
      bit_of = '0;
      for (int k = 1; k < `SADC_SHIFT_W; k++) begin
         bit_of[`SADC_RES_BITS-k] = sh[k];
      end
   endfunction

   // Comparator high keeps the trial bit; low drops it, so V- >= V+ ends at zero
   function automatic logic [`SADC_RES_BITS-1:0] decide(
      input logic [`SADC_RES_BITS-1:0] sar,
      input logic [`SADC_RES_BITS-1:0] bit_sel,
      input logic                      keep
   );
      if (keep) begin
         decide = sar;
      end else begin
         decide = sar & ~bit_sel;
      end
   endfunction

   // Two-flop synchroniser stage shared by every pin
   function automatic logic [1:0] sync2(
      input logic [1:0] stage,
      input logic       raw
   );
      sync2 = {stage[0], raw};
   endfunction

   always_comb begin
      pin.cs_n           = q.sync.s1[1];
      pin.wr_n           = q.sync.s2[1];
      pin.rd_n           = q.sync.s3[1];
      pin.cmp            = q.sync.s4[1];
      set_cond           = !pin.cs_n && !pin.wr_n; // [R8]
      wr_fall            = q.wr_n_prev && !pin.wr_n; // [R6]
      rd_fall            = q.rd_n_prev && !pin.rd_n; // [R16]
      read_on            = !pin.cs_n && !pin.rd_n; // [R14]
      tick               = (q.div == `SADC_DIV_LAST); // [R11]
      first_stage_flop   = q.shift[0];
      // Clear pulse has no effect while the set condition persists
      restart_clear_gate = first_stage_flop && tick && !set_cond; // [R9]
      result_load_gate   = q.shift[`SADC_SHIFT_W-1] && tick; // [R10]
      hold_idle          = (q.hold == '0);
      hold_last          = (q.hold == `SADC_HOLD_W'(1));
      bit_now            = bit_of(q.shift);
      decided            = decide(q.sar, bit_now, pin.cmp); // [R1] [R15]
      next_trial         = decided | (bit_now >> 1); // [R1]
      d                  = q;
      // Two flops on every pin before use
      d.sync.s1   = sync2(q.sync.s1, cs_n);
      d.sync.s2   = sync2(q.sync.s2, wr_n);
      d.sync.s3   = sync2(q.sync.s3, rd_n);
      d.sync.s4   = sync2(q.sync.s4, cmp_hi);
      d.wr_n_prev = pin.wr_n;
      d.rd_n_prev = pin.rd_n;
      d.div       = q.div + `SADC_DIV_W'(1); // [R11]
      if (!hold_idle) begin
         d.hold = q.hold - `SADC_HOLD_W'(1); // [R11] [R12]
      end
      if (set_cond) begin
         // Wide strobe: only the first stage may take the token
         d.start_ff                 = 1'b1; // [R8] [R4] [R13] [R3]
         d.shift[`SADC_SHIFT_W-1:1] = '0; // [R6] [R7] [R9]
         d.sar                      = `SADC_RESULT_RST; // [R6]
         d.done_ff                  = 1'b0; // [R8] [R13] [R16]
         d.hold                     = '0; // [R12]
         d.state                    = sadc_pkg::SADC_ARMED;
         if (tick) begin
            d.shift[0] = 1'b1; // [R8]
         end
      end else if (wr_fall) begin
         // Strobe fell without chip select: search cleared, nothing started
         d.shift = `SADC_SHIFT_CLR; // [R6]
         d.sar   = `SADC_RESULT_RST; // [R6]
         d.state = sadc_pkg::SADC_IDLE;
      end else if (q.start_ff) begin
         d.shift[`SADC_SHIFT_W-1:1] = '0; // [R9]
         d.state                    = sadc_pkg::SADC_ARMED;
         if (restart_clear_gate) begin
            // Token leaves the first stage; top bit is the first trial
            d.start_ff = 1'b0; // [R9] [R7]
            d.shift    = {q.shift[`SADC_SHIFT_W-2:0], 1'b0}; // [R1]
            d.sar      = {1'b1, {(`SADC_RES_BITS-1){1'b0}}}; // [R1]
            d.state    = sadc_pkg::SADC_RUN;
         end else if (tick) begin
            d.shift[0] = 1'b1; // [R8]
         end
      end else if (tick) begin
         // Token walks one stage per eight clocks
         d.shift = {q.shift[`SADC_SHIFT_W-2:0], 1'b0}; // [R1]
         d.sar   = next_trial; // [R1] [R15]
         if (result_load_gate) begin
            d.result = decided; // [R2] [R10]
            d.state  = sadc_pkg::SADC_END;
         end
      end
      // Clears come first, so a completion in the same cycle wins
      if (q.done_ff && hold_idle && read_on) begin
         d.done_ff = 1'b0; // [R14]
      end
      if (rd_fall && !pin.cs_n && hold_idle) begin
         d.done_ff = 1'b0; // [R16]
      end
      if (q.done_ff && hold_last && read_on) begin
         // Held read lets the flag go only after the full hold
         d.done_ff = 1'b0; // [R12]
      end
      if (q.state == sadc_pkg::SADC_END && !set_cond) begin
         // Done set one cycle after the latch load
         d.done_ff = 1'b1; // [R2] [R10]
         d.hold    = `SADC_DONE_HOLD; // [R11] [R12]
         d.state   = sadc_pkg::SADC_IDLE;
      end
      d.oe    = read_on; // [R14] [R17]
      d.trial = q.sar;
      case (d.state)
         sadc_pkg::SADC_IDLE: begin
            busy_d = 1'b0;
         end
         sadc_pkg::SADC_ARMED: begin
            busy_d = 1'b0;
         end
         sadc_pkg::SADC_RUN: begin
            busy_d = 1'b1;
         end
         sadc_pkg::SADC_END: begin
            busy_d = 1'b0;
         end
         default: begin
            busy_d = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         q          <= '0;
         q.sync     <= '1;
         q.wr_n_prev <= 1'b1;
         q.rd_n_prev <= 1'b1;
         q.state    <= sadc_pkg::SADC_IDLE;
      end else if (clk_en) begin
         q <= d;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         data_o      <= `SADC_RESULT_RST;
         data_oe     <= '0;
         done_flag_n <= 1'b1;
         trial_code  <= `SADC_RESULT_RST;
         busy        <= 1'b0;
      end else if (clk_en) begin
         data_o      <= d.result; // [R17]
         data_oe     <= {`SADC_RES_BITS{d.oe}}; // [R14] [R17]
         done_flag_n <= !d.done_ff; // [R10] [R16]
         trial_code  <= d.sar;
         busy        <= busy_d;
      end
   end
endmodule : sadc_ctrl
`default_nettype wire

//--- sim/sadc_ctrl_monitor.sv
// Port checker for the conversion control
`default_nettype none
module sadc_ctrl_monitor (
   // Clock, reset, inputs
   input wire logic       clk, rst_b, clk_en, cs_n, wr_n, rd_n, cmp_hi,
   // Outputs watched
   input wire logic [7:0] trial_code, data_o, data_oe,
   input wire logic       done_flag_n, busy
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   logic [7:0] run_q, len_q;
   // Length of the last search, judged when the flag falls
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         run_q <= 8'h00;
         len_q <= 8'h00;
      end else begin
         run_q <= busy ? run_q + 8'h01 : 8'h00;
         len_q <= busy ? run_q + 8'h01 : len_q;
      end
   end
   sequence s_read; !cs_n && !rd_n && wr_n; endsequence
   sequence s_held; !cs_n && !wr_n; endsequence
   a_oe_released: assert property ((cs_n || rd_n)[*5] |-> data_oe == 8'h00)
      else $error("bus driven while idle");
   a_oe_driven: assert property ((!cs_n && !rd_n)[*5] |-> data_oe == 8'hff)
      else $error("bus not driven in read");
   a_load_then_flag: assert property ($changed(data_o) |=> !done_flag_n)
      else $error("flag not low after load");
   a_flag_hold: assert property ($fell(done_flag_n) ##0 wr_n[*6] |-> !done_flag_n)
      else $error("flag released early");
   a_read_clears: assert property ($fell(done_flag_n) ##0 s_read[*8] ##1 s_read[*8] |-> done_flag_n)
      else $error("read left flag low");
   a_search_len: assert property ($fell(done_flag_n) |-> len_q inside {[8'h40:8'h48]})
      else $error("search length wrong");
   a_reset_hold: assert property (s_held[*8] |-> !busy && done_flag_n)
      else $error("ran while start held");
   a_start_soon: assert property (s_held[*8] ##1 wr_n |-> ##[1:24] busy)
      else $error("no start after release");
   a_msb_first: assert property ($rose(busy) |-> ##[0:2] trial_code == 8'h80)
      else $error("first trial not top bit");
endmodule // sadc_ctrl_monitor
bind sadc_ctrl sadc_ctrl_monitor mon_u (.clk(clk), .rst_b(rst_b), .clk_en(clk_en), .cs_n(cs_n), .wr_n(wr_n),
   .rd_n(rd_n), .cmp_hi(cmp_hi), .trial_code(trial_code), .data_o(data_o), .data_oe(data_oe),
   .done_flag_n(done_flag_n), .busy(busy));
`default_nettype wire

//--- sim/sadc_far_end.sv
// Analog source and start wiring on the far side
`default_nettype none
module sadc_far_end (
   input  wire logic [7:0] level, trial_code,
   input  wire logic       free, wr_req, done_flag_n,
   output logic            cmp_hi, wr_n
);
   timeunit 1ns;
   timeprecision 1ns;
   assign cmp_hi = level >= trial_code;
   // Loop needs one real start pulse first
   assign wr_n = free ? done_flag_n : wr_req;
endmodule // sadc_far_end
`default_nettype wire

//--- sim/sadc_ctrl_bench.sv
// Self-checking bench for the conversion control
`default_nettype none
module sadc_ctrl_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic       clk = 1'b0, rst_b = 1'b0, en = 1'b1, cs_n = 1'b1, rd_n = 1'b1, wr_req = 1'b1, free = 1'b0;
   logic       cmp_hi, wr_n, done_flag_n, busy;
   logic [7:0] level = 8'h00, trial_code, data_o, data_oe;
   int         err_count = 0, compares = 0, cyc = 0;
   always #25 clk = ~clk;
   sadc_far_end far_u (.level(level), .trial_code(trial_code), .free(free), .wr_req(wr_req),
      .done_flag_n(done_flag_n), .cmp_hi(cmp_hi), .wr_n(wr_n));
   sadc_ctrl dut_u (.clk(clk), .rst_b(rst_b), .clk_en(en), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
      .cmp_hi(cmp_hi), .trial_code(trial_code), .data_o(data_o), .data_oe(data_oe),
      .done_flag_n(done_flag_n), .busy(busy));
   task automatic chk(string n, logic [7:0] s, logic [7:0] e);
      compares++;
      if (s !== e) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic conclude();
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic tick(int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic start(logic [7:0] v, int w);
      level = v;
      cs_n = 1'b0;
      wr_req = 1'b0;
      tick(w);
      wr_req = 1'b1;
      cs_n = 1'b1;
   endtask
   task automatic wait_done();
      for (int i = 0; i < 200 && done_flag_n !== 1'b0; i++)
         tick(1);
      chk("done", {7'h00, done_flag_n}, 8'h00);
   endtask
   task automatic read_chk(logic [7:0] v);
      cs_n = 1'b0;
      rd_n = 1'b0;
      tick(5);
      chk("data", data_o, v);
      chk("oe on", data_oe, 8'hff);
      tick(14);
      chk("flag cleared", {7'h00, done_flag_n}, 8'h01);
      cs_n = 1'b1;
      rd_n = 1'b1;
      tick(5);
      chk("oe off", data_oe, 8'h00);
      chk("data kept", data_o, v);
   endtask
   logic [7:0] level_tab [4] = '{8'h00, 8'hff, 8'ha5, 8'h5a};
   task automatic t_levels();
      foreach (level_tab[i]) begin
         start(level_tab[i], 2);
         wait_done();
         read_chk(level_tab[i]);
      end
   endtask
   task automatic t_abort();
      start(8'h33, 2);
      tick(30);
      chk("busy mid", {7'h00, busy}, 8'h01);
      start(8'hc4, 2);
      wait_done();
      read_chk(8'hc4);
   endtask
   task automatic t_wide();
      level = 8'h81;
      cs_n = 1'b0;
      wr_req = 1'b0;
      tick(40);
      chk("held", {6'h00, busy, done_flag_n}, 8'h01);
      wr_req = 1'b1;
      cs_n = 1'b1;
      wait_done();
      read_chk(8'h81);
   endtask
   task automatic t_held_read();
      start(8'h3c, 2);
      tick(1);
      cs_n = 1'b0;
      rd_n = 1'b0;
      wait_done();
      tick(6);
      chk("flag held", {7'h00, done_flag_n}, 8'h00);
      tick(12);
      chk("flag back", {7'h00, done_flag_n}, 8'h01);
      chk("data live", data_o, 8'h3c);
      cs_n = 1'b1;
      rd_n = 1'b1;
      tick(5);
   endtask
   task automatic t_free();
      int n;
      logic p;
      n = 0;
      p = 1'b1;
      start(8'h7e, 2);
      tick(1);
      cs_n = 1'b0;
      free = 1'b1;
      repeat (500) begin
         tick(1);
         n += (p && !done_flag_n) ? 1 : 0;
         p = done_flag_n;
      end
      chk("free runs", {7'h00, n >= 4}, 8'h01);
      free = 1'b0;
      cs_n = 1'b1;
      tick(100);
      chk("free data", data_o, 8'h7e);
   endtask
   initial begin
      tick(12);
      rst_b = 1'b1;
      tick(2);
      t_levels();
      t_abort();
      t_wide();
      t_held_read();
      t_free();
      conclude();
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         err_count++;
         conclude();
      end
   end
endmodule // sadc_ctrl_bench
`default_nettype wire
